// ---- inc/iflg_pkg.sv ----
// How it works
// - slope trip sets flag, software clears
// - slope timer overflow sets sticky flag
// - parallel slave access sets sticky flag
// - eeprom write done sets sticky flag
// - lcd event sets sticky flag
// - comparator change sets sticky flag
// - unimplemented flag bits read zero
// - taken interrupt fetches from fixed vector
// - internal event reaches vector in three cycles
// - external event reaches vector in five cycles (pin synchroniser adds two)
// - latency independent of instruction length
// - edge select picks rising or falling
// - valid selected edge sets external flag
// - external request gated by its enable
// - enabled external edge wakes from halt
// - after wake, vector only if global enable
// - entry pushes only return program counter
// - flags set regardless of enables
package iflg_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] IFLG_OFS_PFLAG = 8'h00;
   localparam logic [7:0] IFLG_OFS_PEN = 8'h04;
   localparam logic [7:0] IFLG_OFS_CTRL = 8'h08;
   localparam logic [7:0] IFLG_OFS_STAT = 8'h0c;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int IFLG_NSRC = 6;
   localparam int IFLG_CTRL_EXTFLAG = 1;
   localparam int IFLG_CTRL_EXTEN = 4;
   localparam int IFLG_CTRL_EDGE = 6;
   localparam int IFLG_CTRL_GIE = 7;
   localparam logic [7:0] IFLG_PFLAG_MASK = 8'h3f;
   localparam logic [7:0] IFLG_CTRL_MASK = 8'hd2;
   localparam logic [7:0] IFLG_RST_BYTE = 8'h00;
   localparam logic [12:0] IFLG_VECTOR = 13'h0004;
   localparam logic [1:0] IFLG_LATENCY = 2'h3;
   typedef struct packed {
      logic [IFLG_NSRC-1:0] pulse;
      logic ext_pin;
   } iflg_evt_s;
endpackage : iflg_pkg

// ---- hdl/iflg_top.sv ----
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module iflg_top
   import iflg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire iflg_evt_s evt,
   input wire logic halted,
   input wire logic [12:0] ret_pc,
   input wire logic core_ack,
   output logic irq_req,
   output logic wake,
   output logic vec_load,
   output logic [12:0] vec_addr,
   output logic push_en,
   output logic [12:0] push_pc
);
   // ----------------------------------------
   // pin synchroniser and edge detect
   // ----------------------------------------
   logic pin_s1_r, pin_s2_r, pin_s3_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
      end else begin
         pin_s1_r <= evt.ext_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] pflag_r, pflag_nxt, pen_r, pen_nxt, ctrl_r, ctrl_nxt;
   logic wr_en, ext_edge;
   assign wr_en = psel & penable & pwrite;

   always_comb begin
      ext_edge = ctrl_r[IFLG_CTRL_EDGE] ? (pin_s2_r & ~pin_s3_r)
                                        : (~pin_s2_r & pin_s3_r);
      pflag_nxt = pflag_r;
      pen_nxt = pen_r;
      ctrl_nxt = ctrl_r;
      if (wr_en && paddr == IFLG_OFS_PFLAG)
         pflag_nxt = pwdata[7:0] & IFLG_PFLAG_MASK;
      if (wr_en && paddr == IFLG_OFS_PEN)
         pen_nxt = pwdata[7:0] & IFLG_PFLAG_MASK;
      if (wr_en && paddr == IFLG_OFS_CTRL)
         ctrl_nxt = pwdata[7:0] & IFLG_CTRL_MASK;
      // set wins over a same-cycle clear; enables ignored
      pflag_nxt[IFLG_NSRC-1:0] = pflag_nxt[IFLG_NSRC-1:0] | evt.pulse;
      if (ext_edge) begin
         ctrl_nxt[IFLG_CTRL_EXTFLAG] = 1'b1;
      end
      if (vec_load) begin
         ctrl_nxt[IFLG_CTRL_GIE] = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pflag_r <= IFLG_RST_BYTE;
         pen_r <= IFLG_RST_BYTE;
         ctrl_r <= IFLG_RST_BYTE;
      end else begin
         pflag_r <= pflag_nxt;
         pen_r <= pen_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   // ----------------------------------------
   // request and latency sequencer
   // ----------------------------------------
   logic pend, any_src;
   assign any_src = (|(pflag_r & pen_r))
                    | (ctrl_r[IFLG_CTRL_EXTFLAG] & ctrl_r[IFLG_CTRL_EXTEN]);
   assign pend = any_src & ctrl_r[IFLG_CTRL_GIE];
   assign wake = halted & any_src;

   typedef enum logic [1:0] {IFLG_IDLE = 2'b01, IFLG_WAIT = 2'b10} iflg_state_e;
   iflg_state_e st_r, st_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic vec_nxt;
   logic [12:0] pc_nxt, pc_r;
   logic take;
   // no new entry while the strobe stands: gie only clears on that edge
   assign take = (st_r == IFLG_IDLE) & pend & ~vec_load;

   // flag registered at cycle 0; counter fixed, so instruction length has no effect
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      vec_nxt = 1'b0;
      pc_nxt = pc_r;
      case (st_r)
         IFLG_IDLE: begin
            if (take) begin
               st_nxt = IFLG_WAIT;
               cnt_nxt = IFLG_LATENCY - 2'h2;
               pc_nxt = ret_pc;
            end
         end
         IFLG_WAIT: begin
            if (cnt_r == 2'h0) begin
               vec_nxt = 1'b1;
               st_nxt = IFLG_IDLE;
            end else begin
               cnt_nxt = cnt_r - 2'h1;
            end
         end
         default: st_nxt = IFLG_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= IFLG_IDLE;
         cnt_r <= 2'h0;
         vec_load <= 1'b0;
         pc_r <= 13'h0000;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         vec_load <= vec_nxt;
         pc_r <= pc_nxt;
      end
   end

   // after wake without global enable no vector is taken: pend stays low
   assign irq_req = pend | (st_r == IFLG_WAIT);
   assign vec_addr = IFLG_VECTOR;
   assign push_en = vec_load;
   assign push_pc = pc_r;

   // ----------------------------------------
   // apb read
   // ----------------------------------------
   logic [31:0] rd_nxt;
   logic rd_err;
   always_comb begin
      rd_nxt = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         IFLG_OFS_PFLAG: rd_nxt = {24'h0, pflag_r & IFLG_PFLAG_MASK};
         IFLG_OFS_PEN: rd_nxt = {24'h0, pen_r};
         IFLG_OFS_CTRL: rd_nxt = {24'h0, ctrl_r};
         IFLG_OFS_STAT: rd_nxt = {28'h0, irq_req, wake, st_r};
         default: rd_err = 1'b1;
      endcase
   end
   assign pready = 1'b1;
   assign prdata = (psel & penable & ~pwrite) ? rd_nxt : 32'h0000_0000;
   assign pslverr = psel & penable & rd_err;

   // ----------------------------------------
   // checks: peripheral flags
   // ----------------------------------------
   AST_SRC_SET: assert property (
      @(posedge core_clk) disable iff (rst)
      evt.pulse[0] |=> pflag_r[0])
      else $error("flag not set");
   AST_SRC_SET1: assert property (
      @(posedge core_clk) disable iff (rst)
      evt.pulse[1] |=> pflag_r[1])
      else $error("overflow flag not set");
   AST_SRC_SET2: assert property (
      @(posedge core_clk) disable iff (rst)
      evt.pulse[2] |=> pflag_r[2])
      else $error("slave access flag not set");
   AST_SRC_SET3: assert property (
      @(posedge core_clk) disable iff (rst)
      evt.pulse[3] |=> pflag_r[3])
      else $error("write done flag not set");
   AST_SRC_SET4: assert property (
      @(posedge core_clk) disable iff (rst)
      evt.pulse[4] |=> pflag_r[4])
      else $error("lcd flag not set");
   AST_SRC_SET5: assert property (
      @(posedge core_clk) disable iff (rst)
      evt.pulse[5] |=> pflag_r[5])
      else $error("comparator flag not set");
   AST_STICKY: assert property (
      @(posedge core_clk) disable iff (rst)
      pflag_r[3] && !(wr_en && paddr == IFLG_OFS_PFLAG) |=> pflag_r[3])
      else $error("flag dropped");
   AST_STICKY_ALL: assert property (
      @(posedge core_clk) disable iff (rst)
      !(wr_en && paddr == IFLG_OFS_PFLAG) |=> ((pflag_r & $past(pflag_r)) == $past(pflag_r)))
      else $error("flag dropped without write");
   AST_STICKY2: assert property (
      @(posedge core_clk) disable iff (rst)
      pflag_r[1] && !(wr_en && paddr == IFLG_OFS_PFLAG) |=> pflag_r[1])
      else $error("overflow flag dropped");
   AST_STICKY5: assert property (
      @(posedge core_clk) disable iff (rst)
      pflag_r[5] && !(wr_en && paddr == IFLG_OFS_PFLAG) |=> pflag_r[5])
      else $error("comparator flag dropped");
   AST_CLR: assert property (
      @(posedge core_clk) disable iff (rst)
      wr_en && paddr == IFLG_OFS_PFLAG && !pwdata[0] && !evt.pulse[0] |=> !pflag_r[0])
      else $error("flag not cleared");
   AST_SET_WINS: assert property (
      @(posedge core_clk) disable iff (rst)
      wr_en && paddr == IFLG_OFS_PFLAG && evt.pulse[2] |=> pflag_r[2])
      else $error("clear beat set");
   AST_RSVD: assert property (
      @(posedge core_clk) disable iff (rst)
      pflag_r[7:6] == 2'b00)
      else $error("reserved bits set");
   AST_RD_RSVD: assert property (
      @(posedge core_clk) disable iff (rst)
      psel && penable && !pwrite && paddr == IFLG_OFS_PFLAG |-> prdata[31:IFLG_NSRC] == '0)
      else $error("reserved bits read");
   AST_NO_GIE_SET: assert property (
      @(posedge core_clk) disable iff (rst)
      evt.pulse[4] && !ctrl_r[IFLG_CTRL_GIE] |=> pflag_r[4])
      else $error("flag gated by gie");
   AST_NO_EN_SET: assert property (
      @(posedge core_clk) disable iff (rst)
      evt.pulse[5] && !pen_r[5] |=> pflag_r[5])
      else $error("flag gated by enable");

   // ----------------------------------------
   // checks: request and vector
   // ----------------------------------------
   AST_LAT: assert property (
      @(posedge core_clk) disable iff (rst)
      take |=> !vec_load [*2] ##1 vec_load)
      else $error("latency wrong");
   AST_LAT_ST: assert property (
      @(posedge core_clk) disable iff (rst)
      take |=> st_r == IFLG_WAIT [*2] ##1 st_r == IFLG_IDLE)
      else $error("latency sequence wrong");
   AST_VEC_ONE: assert property (
      @(posedge core_clk) disable iff (rst)
      vec_load |=> !vec_load)
      else $error("vector strobe too long");
   AST_VEC: assert property (
      @(posedge core_clk) disable iff (rst)
      vec_load |-> vec_addr == IFLG_VECTOR && push_en)
      else $error("vector");
   AST_PUSH_PC: assert property (
      @(posedge core_clk) disable iff (rst)
      vec_load |-> push_pc == $past(ret_pc, 3))
      else $error("pushed pc wrong");
   AST_GIE_CLR: assert property (
      @(posedge core_clk) disable iff (rst)
      vec_load |=> !ctrl_r[IFLG_CTRL_GIE])
      else $error("gie kept on entry");
   AST_GATE: assert property (
      @(posedge core_clk) disable iff (rst)
      !ctrl_r[IFLG_CTRL_GIE] && st_r == IFLG_IDLE |-> !irq_req)
      else $error("req without gie");
   AST_REQ: assert property (
      @(posedge core_clk) disable iff (rst)
      (|(pflag_r & pen_r)) && ctrl_r[IFLG_CTRL_GIE] |-> irq_req)
      else $error("no req");
   AST_NO_VEC_WO_GIE: assert property (
      @(posedge core_clk) disable iff (rst)
      !ctrl_r[IFLG_CTRL_GIE] && st_r == IFLG_IDLE |=> !vec_load)
      else $error("vector without gie");

   // ----------------------------------------
   // checks: external pin
   // ----------------------------------------
   AST_EDGE: assert property (
      @(posedge core_clk) disable iff (rst)
      ext_edge |=> ctrl_r[IFLG_CTRL_EXTFLAG])
      else $error("ext flag");
   AST_RISE_ONLY: assert property (
      @(posedge core_clk) disable iff (rst)
      ctrl_r[IFLG_CTRL_EDGE] && !pin_s2_r |-> !ext_edge)
      else $error("edge on low pin");
   AST_FALL_ONLY: assert property (
      @(posedge core_clk) disable iff (rst)
      !ctrl_r[IFLG_CTRL_EDGE] && pin_s2_r |-> !ext_edge)
      else $error("edge on high pin");
   AST_EXT_NO_EN: assert property (
      @(posedge core_clk) disable iff (rst)
      ext_edge && !ctrl_r[IFLG_CTRL_EXTEN] |=> ctrl_r[IFLG_CTRL_EXTFLAG])
      else $error("ext flag gated");
   AST_EXT_GATE: assert property (
      @(posedge core_clk) disable iff (rst)
      !ctrl_r[IFLG_CTRL_EXTEN] && !(|(pflag_r & pen_r)) |-> !wake)
      else $error("ext request not gated");
   AST_WAKE: assert property (
      @(posedge core_clk) disable iff (rst)
      halted && ctrl_r[IFLG_CTRL_EXTFLAG] && ctrl_r[IFLG_CTRL_EXTEN] |-> wake)
      else $error("no wake");

   COV_IRQ: cover property (@(posedge core_clk)
      vec_load);
   COV_EXT: cover property (@(posedge core_clk)
      ext_edge);
   COV_WAKE: cover property (@(posedge core_clk)
      wake && !ctrl_r[IFLG_CTRL_GIE]);
   COV_SET_WINS: cover property (@(posedge core_clk)
      wr_en && paddr == IFLG_OFS_PFLAG && (|evt.pulse));
   COV_EXT_IRQ: cover property (@(posedge core_clk)
      vec_load && ctrl_r[IFLG_CTRL_EXTFLAG]);
endmodule : iflg_top

// ---- tb/iflg_partner.sv ----
`timescale 1ns/100ps
module iflg_partner
   import iflg_pkg::*;
(
   input wire logic [IFLG_NSRC-1:0] req,
   input wire logic pin,
   output iflg_evt_s evt
);
   // -----
   // event sources
   // -----
   assign evt.pulse = req;
   assign evt.ext_pin = pin;
endmodule : iflg_partner

// ---- tb/interrupt_flags_and_ext_edge_irq_test.sv ----
`timescale 1ns/100ps
module interrupt_flags_and_ext_edge_irq_test
   import iflg_pkg::*;
;
   localparam logic [12:0] PC = 13'h0123;
   logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, halted = 0, pin = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, irq_req, wake, vec_load, push_en, e;
   logic [12:0] vec_addr, push_pc;
   logic [IFLG_NSRC-1:0] req = '0;
   iflg_evt_s evt;
   int mismatches = 0, n_tests = 0;
   iflg_partner part (.req(req), .pin(pin), .evt(evt));
   iflg_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt(evt), .halted(halted), .ret_pc(PC), .core_ack(1'b0),
      .irq_req(irq_req), .wake(wake), .vec_load(vec_load), .vec_addr(vec_addr),
      .push_en(push_en), .push_pc(push_pc));
   // -----
   // shared tasks
   // -----
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask : check
   task automatic finish_test;
      $display("%0d mismatches in %0d checks", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         mismatches++;
         finish_test;
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic edge_to(input logic v);
      @(posedge core_clk);
      pin <= v;
      repeat (6) @(posedge core_clk);
   endtask : edge_to
   // -----
   // scenarios
   // -----
   task automatic t_regs;
      apb(0, IFLG_OFS_PFLAG, 0);
      check("pflag rst", 0, q);
      apb(0, IFLG_OFS_CTRL, 0);
      check("ctrl rst", 0, q);
      apb(0, 8'h10, 0);
      check("unmapped err", 1, e);
      apb(1, IFLG_OFS_PFLAG, 32'hff);
      apb(0, IFLG_OFS_PFLAG, 0);
      check("pflag mask", 32'h3f, q);
      apb(1, IFLG_OFS_PFLAG, 0);
      $display("regs done");
   endtask : t_regs
   task automatic t_flags;
      for (int i = 0; i < IFLG_NSRC; i++) begin
         @(posedge core_clk);
         req <= 6'(1 << i);
         @(posedge core_clk);
         req <= '0;
         apb(0, IFLG_OFS_PFLAG, 0);
         check("flags", (2 << i) - 1, q);
      end
      apb(1, IFLG_OFS_PFLAG, 0);
      apb(0, IFLG_OFS_PFLAG, 0);
      check("flags clr", 0, q);
      $display("flags done");
   endtask : t_flags
   task automatic t_latency;
      int n;
      apb(1, IFLG_OFS_PEN, 1);
      apb(1, IFLG_OFS_CTRL, 32'h80);
      @(posedge core_clk);
      req <= 6'h01;
      @(posedge core_clk);
      req <= '0;
      // flag is set at this edge; count edges from here
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (vec_load !== 1'b1 && n < 10);
      check("latency", 3, n);
      check("vector", IFLG_VECTOR, vec_addr);
      check("push", {1'b1, PC}, {push_en, push_pc});
      #4 check("irq after entry", 0, irq_req);
      apb(1, IFLG_OFS_PFLAG, 0);
      $display("latency done");
   endtask : t_latency
   task automatic t_edge;
      for (int s = 0; s < 2; s++) begin
         edge_to(!s);
         apb(1, IFLG_OFS_CTRL, 32'(s << 6));
         edge_to(s);
         apb(0, IFLG_OFS_CTRL, 0);
         check("ext flag", 32'(s << 6) | 2, q);
         apb(1, IFLG_OFS_CTRL, 32'(s << 6));
         edge_to(!s);
         apb(0, IFLG_OFS_CTRL, 0);
         check("wrong edge", 32'(s << 6), q);
      end
      $display("edge done");
   endtask : t_edge
   task automatic t_wake;
      halted <= 1;
      apb(1, IFLG_OFS_CTRL, 32'h50);
      edge_to(1);
      check("wake", 1, wake);
      check("no vector", 0, irq_req);
      apb(1, IFLG_OFS_CTRL, 32'hc0);
      edge_to(0);
      edge_to(1);
      check("gated", 0, {wake, irq_req});
      apb(0, IFLG_OFS_CTRL, 0);
      check("flag w/o enable", 32'hc2, q);
      $display("wake done");
   endtask : t_wake
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 0;
      t_regs;
      t_flags;
      t_latency;
      t_edge;
      t_wake;
      finish_test;
   end
endmodule : interrupt_flags_and_ext_edge_irq_test
